// [lzv_pkg.sv]
package lzv_pkg;

  // ==========================================================================
  // Register map (I/O addresses)
  // ==========================================================================
  localparam logic [7:0] LZV_VECTOR_LOW_ADDR = 8'h33;
  localparam logic [7:0] LZV_EDGE_CTRL_ADDR  = 8'hDF;
  localparam logic [7:0] LZV_TRAP_CTRL_ADDR  = 8'h34;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int          LZV_VEC_HI_LSB     = 5;
  localparam int          LZV_IRQ2_MODE_LSB  = 6;
  localparam int          LZV_IRQ2_SENSE_BIT = 3;
  localparam logic [2:0]  LZV_VEC_HI_RST     = 3'h0;
  localparam logic [2:0]  LZV_SRC_EN_RST     = 3'h1;
  localparam logic [1:0]  LZV_IRQ2_MODE_RST  = 2'h0;
  localparam logic [7:0]  LZV_PAGE_RST       = 8'h00;
  localparam logic [15:0] LZV_MODE1_TARGET   = 16'h0038;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          LZV_CLK_PERIOD_PS  = 5000;
  localparam int          LZV_ACK_TIME_PS    = 20000;
  localparam int          LZV_ACK_CYCLES     = (LZV_ACK_TIME_PS + LZV_CLK_PERIOD_PS - 1)
                                               / LZV_CLK_PERIOD_PS;
  localparam logic [3:0]  LZV_ACK_LAST       = 4'(LZV_ACK_CYCLES - 1);

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {LZV_IM0, LZV_IM1, LZV_IM2} lzv_mode_e;

  typedef enum logic [2:0] {
    LZV_IDLE, LZV_ACK, LZV_EXEC, LZV_PUSH, LZV_VLO, LZV_VHI, LZV_JUMP
  } lzv_state_e;

  typedef struct packed {
    logic opcodeFetchStrobeN;
    logic ioRequestStrobeN;
  } lzv_ack_pins_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } lzv_jump_s;

endpackage : lzv_pkg

// [lzv_edge_capture.sv]
`timescale 1ns/100ps
`default_nettype none

module lzv_edge_capture
  import lzv_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstInt_n,
  // Pin level, already synchronised
  input  wire logic       pinLevel,
  // Control
  input  wire logic [1:0] mode,
  input  wire logic       unlatch,
  // Request towards the processor
  output var  logic       reqN
);

  logic prev_q, prev_d;
  logic latch_q, latch_d;
  logic reqN_q, reqN_d;
  logic edgeSeen;

  always_comb
  begin
    edgeSeen = mode[0] ? (pinLevel && !prev_q) : (!pinLevel && prev_q);
    prev_d   = pinLevel;
    latch_d  = latch_q;
    // R18: latch holds until unlatch write or until level mode is selected
    if (unlatch)
      latch_d = 1'b0;
    // Edge arriving with the unlatch write still sets
    if (mode[1] && edgeSeen)
      latch_d = 1'b1;
    if (!mode[1])
      latch_d = 1'b0;
    // R21: level mode follows the pin
    reqN_d = mode[1] ? !latch_d : pinLevel;
  end

  always_ff @(posedge clk or negedge rstInt_n)
  begin
    if (!rstInt_n)
    begin
      prev_q  <= 1'b1;
      latch_q <= 1'b0;
      reqN_q  <= 1'b1;
    end
    else
    begin
      prev_q  <= prev_d;
      latch_q <= latch_d;
      reqN_q  <= reqN_d;
    end
  end

  assign reqN = reqN_q;

endmodule // lzv_edge_capture

`default_nettype wire

// [lzv_level0_ctrl.sv]
// Summary of operation
// R1: Level 0 ranks below NMI; serves serial, timers, parallel port, ext pin 0.
// R2: Four active-low requests ANDed; sampled in second-last instruction cycle.
// R3: Take interrupt only if sample low, source enable set, global enable set.
// R4: No maskable interrupt right after enable-type instructions.
// R5: Three processing modes 0, 1, 2 chosen by mode instruction.
// R6: Mode 0: clear enables, ack cycle with both strobes low, read opcode.
// R7: Mode 0 executes supplied instruction, no automatic PC push.
// R8: Invalid multibyte instruction in mode 0 ack raises trap.
// R9: Supplied restart opcode pushes PC and jumps to 0..38H.
// R10: Mode 1 clears enables, pushes PC, jumps to 0038H, no ack read.
// R11: Page register has no I/O address; loaded and read by instructions.
// R12: Page register drives upper address while fetching routine address.
// R13: Mode 2 clears enables, same ack cycle, byte taken as vector.
// R14: Interrupting device supplies vector with bit 0 clear.
// R15: Mode 2 pushes PC, reads low then high routine byte, jumps.
// R16: Vector low bits 7..5 feed synthesized vectors; reset clears them.
// R17: Edge register bits 7..6 select level, falling or rising capture.
// R18: Latched edge cleared only by writing 1 to edge register bit 3; the code also clears it whenever bits 7..6 select level mode.
// R19: Bit 3 reads pin level; write 1 clears latch, 0 does nothing.
// R20: Reset sets level 0 enable, clears interrupt 1 and 2 enables.
// R21: Level mode interrupt 2 request follows the pin directly.
`timescale 1ns/100ps
`default_nettype none

module lzv_level0_ctrl
  import lzv_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Level 0 request sources and the interrupt 2 pin
  input  wire logic          serialIrqN,
  input  wire logic          timerIrqN,
  input  wire logic          parallelIrqN,
  input  wire logic          ext_irq0_n,
  input  wire logic          ext_irq2_n,
  // Instruction events from the core
  input  wire logic          instrSample,
  input  wire logic          instrDone,
  input  wire logic          noIrqAfter,
  input  wire logic          nmiTaken,
  input  wire logic          irq_enable_instr,
  input  wire logic          irqDisableInstr,
  input  wire logic          retnInstr,
  input  wire logic          irq_mode_select_instr,
  input  wire logic [1:0]    modeSel,
  input  wire logic          loadPageInstr,
  input  wire logic [7:0]    accData,
  // Opcode hand-off for mode 0
  input  wire logic          opcodeDone,
  input  wire logic          opcodeBad,
  // Stack push and vector memory reads
  input  wire logic          pushDone,
  input  wire logic          memRdAck,
  input  wire logic [7:0]    memRdData,
  // Acknowledge data bus
  input  wire logic [7:0]    dataBus,
  // I/O register access
  input  wire logic          ioWrEn,
  input  wire logic          ioRdEn,
  input  wire logic [7:0]    ioAddr,
  input  wire logic [7:0]    ioWrData,
  output var  logic [7:0]    ioRdData,
  // Acknowledge strobes
  output var  lzv_ack_pins_s ackPins,
  // Core control
  output var  logic          cpuHold,
  output var  logic          pushReq,
  output var  lzv_jump_s     jump,
  output var  logic          opcodeValid,
  output var  logic [7:0]    opcodeByte,
  output var  logic          trapReq,
  output var  logic          memRdReq,
  output var  logic [15:0]   memAddr,
  // Flags and shared state
  output var  logic          global_irq_enable_flag,
  output var  logic          saved_irq_enable_flag,
  output var  logic [7:0]    pageReg,
  output var  logic [2:0]    vectorHiBits,
  output var  logic [2:0]    srcEnable,
  output var  logic          irq2ReqN
);

  // ==========================================================================
  // Reset release and pin synchronisers
  // ==========================================================================
  logic [1:0] rstSync_q;
  logic       rstInt_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end

  assign rstInt_n = rstSync_q[1];

  // Data bus is only read after the strobes have been low long enough
  logic [9:0] pinMeta_q, pinSync_q;
  logic       irq0Sync, irq2Sync;
  logic [7:0] dataSync;

  always_ff @(posedge clk or negedge rstInt_n)
  begin
    if (!rstInt_n)
    begin
      pinMeta_q <= 10'h3FF;
      pinSync_q <= 10'h3FF;
    end
    else
    begin
      pinMeta_q <= {ext_irq0_n, ext_irq2_n, dataBus};
      pinSync_q <= pinMeta_q;
    end
  end

  assign irq0Sync = pinSync_q[9];
  assign irq2Sync = pinSync_q[8];
  assign dataSync = pinSync_q[7:0];

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic isRestart(input logic [7:0] op);
    isRestart = (op[7:6] == 2'b11) && (op[2:0] == 3'b111);
  endfunction

  function automatic logic [15:0] restartTarget(input logic [7:0] op);
    restartTarget = {10'h000, op[5:3], 3'b000};
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  // One record for all state apart from the synchronisers and the interrupt-2 capture keeps reset and registering in one place
  typedef struct packed {
    lzv_state_e    state;
    lzv_mode_e     mode;
    logic          gie;
    logic          sie;
    logic          sampled;
    logic          blocked;
    logic [2:0]    srcEn;
    logic [2:0]    vecHi;
    logic [1:0]    irq2Mode;
    logic [7:0]    page;
    logic [3:0]    cnt;
    logic [7:0]    vec;
    logic [7:0]    isrLo;
    logic [15:0]   target;
    logic [15:0]   memAddr;
    logic          memRdReq;
    logic          pushReq;
    logic          hold;
    lzv_jump_s     jump;
    lzv_ack_pins_s ack;
    logic          opValid;
    logic          trap;
    logic [7:0]    rdData;
  } lzv_regs_s;

  lzv_regs_s regs_q, regs_d;
  logic      composite;
  logic      take;
  logic      unlatch;

  // R1: all four sources share one level
  // R2: active-low requests combine by AND
  assign composite = serialIrqN & timerIrqN & parallelIrqN & irq0Sync;

  // R19: writing 1 to the sense bit unlatches
  assign unlatch = ioWrEn && (ioAddr == LZV_EDGE_CTRL_ADDR) && ioWrData[LZV_IRQ2_SENSE_BIT];

  // R3: sampled low, source enabled, globally enabled
  // R4: instruction that forbids a following interrupt
  assign take = instrDone && !regs_q.sampled && regs_q.srcEn[0] && regs_q.gie
                && !regs_q.blocked && !noIrqAfter && !nmiTaken
                && (regs_q.state == LZV_IDLE);

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb
  begin
    regs_d = regs_q;
    // Strobes towards the core last one cycle
    {regs_d.memRdReq, regs_d.pushReq, regs_d.jump.valid, regs_d.opValid, regs_d.trap} = 5'h00;

    // R2: composite caught in second-last cycle
    if (instrSample)
      regs_d.sampled = composite;
    // R4: also blocks the next boundary, so two instruction boundaries in all
    if (instrDone)
      regs_d.blocked = noIrqAfter;

    if (irq_enable_instr)
      {regs_d.gie, regs_d.sie} = 2'b11;
    if (irqDisableInstr)
      {regs_d.gie, regs_d.sie} = 2'b00;
    if (retnInstr)
      regs_d.gie = regs_q.sie;
    // R1: NMI outranks level 0; prior enable is saved
    if (nmiTaken)
      {regs_d.gie, regs_d.sie} = {1'b0, regs_q.gie};

    // R5: mode instruction picks 0, 1 or 2; code 3 is ignored
    if (irq_mode_select_instr && modeSel != 2'd3)
      regs_d.mode = lzv_mode_e'(modeSel);

    // R11: page register loaded only by instruction
    if (loadPageInstr)
      regs_d.page = accData;

    if (ioWrEn)
      unique case (ioAddr)
        // R16: vector low bits 7..5 are programmable
        LZV_VECTOR_LOW_ADDR: regs_d.vecHi = ioWrData[7:LZV_VEC_HI_LSB];
        // R17: interrupt-2 capture mode
        LZV_EDGE_CTRL_ADDR:  regs_d.irq2Mode = ioWrData[7:LZV_IRQ2_MODE_LSB];
        LZV_TRAP_CTRL_ADDR:  regs_d.srcEn = ioWrData[2:0];
        default:             regs_d.srcEn = regs_q.srcEn;
      endcase

    // Reads answer the next cycle; unmapped addresses read zero
    if (ioRdEn)
      unique case (ioAddr)
        LZV_VECTOR_LOW_ADDR: regs_d.rdData = {regs_q.vecHi, 5'h00};
        // R19: sense bit shows the pin level
        LZV_EDGE_CTRL_ADDR:  regs_d.rdData = {regs_q.irq2Mode, 2'b00, irq2Sync, 3'b000};
        LZV_TRAP_CTRL_ADDR:  regs_d.rdData = {5'h00, regs_q.srcEn};
        default:             regs_d.rdData = 8'h00;
      endcase

    unique case (regs_q.state)
      LZV_IDLE:
        if (take)
        begin
          // R6: R10: R13: every mode disables both flags first
          {regs_d.gie, regs_d.sie} = 2'b00;
          regs_d.hold              = 1'b1;
          regs_d.cnt               = 4'h0;
          if (regs_q.mode == LZV_IM1)
          begin
            // R10: fixed target, no acknowledge read
            regs_d.target  = LZV_MODE1_TARGET;
            regs_d.pushReq = 1'b1;
            regs_d.state   = LZV_PUSH;
          end
          else
          begin
            // R6: R13: both strobes low together
            regs_d.ack   = '{opcodeFetchStrobeN: 1'b0, ioRequestStrobeN: 1'b0};
            regs_d.state = LZV_ACK;
          end
        end
      LZV_ACK:
      begin
        regs_d.cnt = regs_q.cnt + 4'h1;
        // Bus has cleared both sync flops by the last strobe cycle
        if (regs_q.cnt == LZV_ACK_LAST)
        begin
          regs_d.ack = '{opcodeFetchStrobeN: 1'b1, ioRequestStrobeN: 1'b1};
          regs_d.vec = dataSync;
          if (regs_q.mode == LZV_IM2)
          begin
            // R13: byte is a vector; R14: device keeps bit 0 clear
            regs_d.pushReq = 1'b1;
            regs_d.state   = LZV_PUSH;
          end
          else if (isRestart(dataSync))
          begin
            // R9: restart pushes PC and jumps
            regs_d.target  = restartTarget(dataSync);
            regs_d.pushReq = 1'b1;
            regs_d.state   = LZV_PUSH;
          end
          else
          begin
            // R7: core runs supplied opcode, no push
            regs_d.opValid = 1'b1;
            regs_d.state   = LZV_EXEC;
          end
        end
      end
      LZV_EXEC:
        if (opcodeDone)
        begin
          // R8: invalid multibyte sequence traps
          regs_d.trap  = opcodeBad;
          regs_d.hold  = 1'b0;
          regs_d.state = LZV_IDLE;
        end
      LZV_PUSH:
        if (pushDone && regs_q.mode == LZV_IM2)
        begin
          // R12: R15: page on upper lines, vector below
          regs_d.memAddr  = {regs_q.page, regs_q.vec};
          regs_d.memRdReq = 1'b1;
          regs_d.state    = LZV_VLO;
        end
        else if (pushDone)
          regs_d.state = LZV_JUMP;
      LZV_VLO:
        if (memRdAck)
        begin
          // R15: low half, then next higher address
          regs_d.isrLo    = memRdData;
          regs_d.memAddr  = regs_q.memAddr + 16'h0001;
          regs_d.memRdReq = 1'b1;
          regs_d.state    = LZV_VHI;
        end
      LZV_VHI:
        if (memRdAck)
        begin
          regs_d.target = {memRdData, regs_q.isrLo};
          regs_d.state  = LZV_JUMP;
        end
      LZV_JUMP:
      begin
        regs_d.jump  = '{valid: 1'b1, addr: regs_q.target};
        regs_d.hold  = 1'b0;
        regs_d.state = LZV_IDLE;
      end
      default:
        regs_d.state = LZV_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk or negedge rstInt_n)
  begin
    if (!rstInt_n)
    begin
      regs_q          <= '0;
      // R6: reset selects mode 0
      regs_q.mode     <= LZV_IM0;
      // No stale request may be taken straight after reset
      regs_q.sampled  <= 1'b1;
      // R20: level 0 enabled, levels 1 and 2 off
      regs_q.srcEn    <= LZV_SRC_EN_RST;
      // R16: reset clears vector bits
      regs_q.vecHi    <= LZV_VEC_HI_RST;
      regs_q.irq2Mode <= LZV_IRQ2_MODE_RST;
      regs_q.page     <= LZV_PAGE_RST;
      regs_q.ack      <= '{opcodeFetchStrobeN: 1'b1, ioRequestStrobeN: 1'b1};
    end
    else
      regs_q <= regs_d;
  end

  // ==========================================================================
  // Interrupt-2 capture
  // ==========================================================================
  // R17: R18: R21: capture mode and unlatch
  lzv_edge_capture u_irq2Capture (
    .clk      (clk),
    .rstInt_n (rstInt_n),
    .pinLevel (irq2Sync),
    .mode     (regs_q.irq2Mode),
    .unlatch  (unlatch),
    .reqN     (irq2ReqN)
  );

  assign ioRdData               = regs_q.rdData;
  assign ackPins                = regs_q.ack;
  assign cpuHold                = regs_q.hold;
  assign pushReq                = regs_q.pushReq;
  assign jump                   = regs_q.jump;
  assign opcodeValid            = regs_q.opValid;
  assign opcodeByte             = regs_q.vec;
  assign trapReq                = regs_q.trap;
  assign memRdReq               = regs_q.memRdReq;
  assign memAddr                = regs_q.memAddr;
  assign global_irq_enable_flag = regs_q.gie;
  assign saved_irq_enable_flag  = regs_q.sie;
  // R11: R12: read back and upper address for vectored fetches
  assign pageReg                = regs_q.page;
  // R16: bits 7..5 of synthesized vectors
  assign vectorHiBits           = regs_q.vecHi;
  assign srcEnable              = regs_q.srcEn;

endmodule // lzv_level0_ctrl

`default_nettype wire

// [lzv_props.sv]
`timescale 1ns/100ps
`default_nettype none

module lzv_props
  import lzv_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // Core events
  input wire logic          instrDone,
  input wire logic          noIrqAfter,
  input wire logic          irq_mode_select_instr,
  input wire logic [1:0]    modeSel,
  input wire logic          loadPageInstr,
  input wire logic [7:0]    accData,
  // Sequence outputs
  input wire lzv_ack_pins_s ackPins,
  input wire logic          cpuHold,
  input wire logic          pushReq,
  input wire lzv_jump_s     jump,
  input wire logic          memRdReq,
  input wire logic [15:0]   memAddr,
  // Flags and state
  input wire logic          global_irq_enable_flag,
  input wire logic          saved_irq_enable_flag,
  input wire logic [7:0]    pageReg,
  input wire logic [2:0]    srcEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [1:0] modeQ;
  logic [1:0] modeD;
  logic       en0;

  assign en0 = srcEnable[0];

  // Shadow of the selected mode; code 3 is ignored
  always_comb
  begin
    modeD = modeQ;
    if (irq_mode_select_instr && modeSel != 2'h3)
      modeD = modeSel;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      modeQ <= 2'h0;
    else
      modeQ <= modeD;
  end

  a_strobe_pair:
    assert property (ackPins.opcodeFetchStrobeN == ackPins.ioRequestStrobeN)
    else $error("ack strobes differ");
  a_ack_length:
    assert property ($fell(ackPins.ioRequestStrobeN) |->
      (!ackPins.ioRequestStrobeN)[*4] ##1 ackPins.ioRequestStrobeN)
    else $error("ack length wrong");
  a_ack_clears_flags:
    assert property ($fell(ackPins.ioRequestStrobeN) |->
      !global_irq_enable_flag && !saved_irq_enable_flag)
    else $error("flags not cleared");
  a_take_gate:
    assert property ($fell(ackPins.ioRequestStrobeN) |->
      $past(instrDone) && $past(en0) && $past(global_irq_enable_flag))
    else $error("take not gated");
  a_block_after:
    assert property (instrDone && noIrqAfter && !cpuHold |=>
      ackPins.ioRequestStrobeN && !pushReq)
    else $error("blocked boundary taken");
  a_mode1_noack:
    assert property ($fell(ackPins.ioRequestStrobeN) |-> modeQ != 2'h1)
    else $error("ack cycle in mode 1");
  a_mode1_target:
    assert property (jump.valid && modeQ == 2'h1 |-> jump.addr == LZV_MODE1_TARGET)
    else $error("mode 1 target wrong");
  a_vec_page:
    assert property (memRdReq |-> memAddr[15:8] == pageReg)
    else $error("page not on upper address");
  a_page_load:
    assert property (loadPageInstr |=> pageReg == $past(accData))
    else $error("page load wrong");

  c_ack: cover property ($fell(ackPins.ioRequestStrobeN));
  c_mode1: cover property (jump.valid && modeQ == 2'h1);
  c_vec_hi: cover property (memRdReq && memAddr[0]);
endmodule // lzv_props

bind lzv_level0_ctrl lzv_props u_props (
  .clk(clk), .rst_n(rst_n), .instrDone(instrDone), .noIrqAfter(noIrqAfter),
  .irq_mode_select_instr(irq_mode_select_instr), .modeSel(modeSel),
  .loadPageInstr(loadPageInstr), .accData(accData), .ackPins(ackPins),
  .cpuHold(cpuHold), .pushReq(pushReq), .jump(jump), .memRdReq(memRdReq),
  .memAddr(memAddr), .global_irq_enable_flag(global_irq_enable_flag),
  .saved_irq_enable_flag(saved_irq_enable_flag), .pageReg(pageReg),
  .srcEnable(srcEnable));

`default_nettype wire

// [lzv_partner.sv]
`timescale 1ns/100ps
`default_nettype none

module lzv_partner
  import lzv_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Acknowledge cycle
  input  wire lzv_ack_pins_s ackPins,
  input  wire logic [7:0]    ackByte,
  output var  logic [7:0]    dataBus,
  // Stack and vector memory
  input  wire logic          slow,
  input  wire logic          pushReq,
  input  wire logic          memRdReq,
  input  wire logic [15:0]   memAddr,
  output var  logic          pushDone,
  output var  logic          memRdAck,
  output var  logic [7:0]    memRdData
);
  logic [7:0] lastQ = 8'h5A;
  int         rdCnt = 0;
  int         pushCnt = 0;

  // byte only while both strobes low, else a changing pattern
  assign dataBus = (ackPins == 2'h0) ? ackByte : ~lastQ;

  always @(posedge clk)
  begin
    lastQ <= dataBus;
    memRdAck <= 1'b0;
    pushDone <= 1'b0;
    memRdData <= ~memRdData;
    rdCnt <= memRdReq ? (slow ? 4 : 1) : (rdCnt > 0 ? rdCnt - 1 : 0);
    pushCnt <= pushReq ? (slow ? 3 : 1) : (pushCnt > 0 ? pushCnt - 1 : 0);
    if (rdCnt == 1)
    begin
      memRdAck <= 1'b1;
      memRdData <= memAddr[7:0] ^ memAddr[15:8] ^ 8'hA5;
    end
    if (pushCnt == 1)
      pushDone <= 1'b1;
  end
endmodule // lzv_partner

`default_nettype wire

// [tb_level0_interrupt_vectoring.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_level0_interrupt_vectoring
  import lzv_pkg::*;
;
  logic          clk = 1'b0, rst_n = 1'b0, irq2N = 1'b1, zero = 1'b0;
  logic          sample = 1'b0, done = 1'b0, block = 1'b0, enI = 1'b0;
  logic          modeI = 1'b0, ldPage = 1'b0, opDone = 1'b0, opBad = 1'b0;
  logic          wrEn = 1'b0, rdEn = 1'b0, slow = 1'b0;
  logic [3:0]    srcN = 4'hF;
  logic [1:0]    modeSel = 2'h0;
  logic [7:0]    acc = 8'h00, ioAddr = 8'h00, ioWr = 8'h00, ackByte = 8'h00;
  lzv_ack_pins_s ackPins;
  lzv_jump_s     jump;
  logic [7:0]    dataBus, memRdData, ioRdData, opcodeByte, pageReg, lo;
  logic [15:0]   memAddr;
  logic          pushDone, memRdAck, cpuHold, pushReq, opcodeValid, trapReq;
  logic          memRdReq, gFlag, sFlag, irq2ReqN;
  logic [15:0]   expQ[$];
  int            n_fail = 0, n_checks = 0, nPush = 0, nTrap = 0, seed = 53189;

  always #2.5 clk = ~clk;

  lzv_level0_ctrl uut (
    .clk(clk), .rst_n(rst_n), .serialIrqN(srcN[0]), .timerIrqN(srcN[1]),
    .parallelIrqN(srcN[2]), .ext_irq0_n(srcN[3]), .ext_irq2_n(irq2N),
    .instrSample(sample), .instrDone(done), .noIrqAfter(block), .nmiTaken(zero),
    .irq_enable_instr(enI), .irqDisableInstr(zero), .retnInstr(zero),
    .irq_mode_select_instr(modeI), .modeSel(modeSel), .loadPageInstr(ldPage),
    .accData(acc), .opcodeDone(opDone), .opcodeBad(opBad), .pushDone(pushDone),
    .memRdAck(memRdAck), .memRdData(memRdData), .dataBus(dataBus), .ioWrEn(wrEn),
    .ioRdEn(rdEn), .ioAddr(ioAddr), .ioWrData(ioWr), .ioRdData(ioRdData),
    .ackPins(ackPins), .cpuHold(cpuHold), .pushReq(pushReq), .jump(jump),
    .opcodeValid(opcodeValid), .opcodeByte(opcodeByte), .trapReq(trapReq),
    .memRdReq(memRdReq), .memAddr(memAddr), .global_irq_enable_flag(gFlag),
    .saved_irq_enable_flag(sFlag), .pageReg(pageReg), .vectorHiBits(),
    .srcEnable(), .irq2ReqN(irq2ReqN));

  lzv_partner partner (
    .clk(clk), .ackPins(ackPins), .ackByte(ackByte), .dataBus(dataBus),
    .slow(slow), .pushReq(pushReq), .memRdReq(memRdReq), .memAddr(memAddr),
    .pushDone(pushDone), .memRdAck(memRdAck), .memRdData(memRdData));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [15:0] pop();
    if (expQ.size() == 0)
      return 'x;
    return expQ.pop_front();
  endfunction

  // ==========================================================================
  // Result watcher, 1 ns after each rising edge once its updates land
  always @(posedge clk)
  begin : watch
    logic rd;
    rd = rdEn;
    #1;
    if (pushReq) nPush++;
    if (trapReq) nTrap++;
    if (rd) chk(16'(ioRdData), pop());
    if (jump.valid) chk(jump.addr, pop());
    if (opcodeValid) chk(16'(opcodeByte), pop());
  end

  // ==========================================================================
  // Drivers, entered just after a falling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ioAddr = a;
    ioWr = d;
    pulse(wrEn);
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back({8'h00, e});
    ioAddr = a;
    pulse(rdEn);
    cyc(1);
  endtask

  task automatic boundary(input logic blk);
    pulse(sample);
    block = blk;
    pulse(done);
    block = 1'b0;
  endtask

  task automatic settle(input logic hold);
    int k;
    k = 0;
    while ((expQ.size() != 0 || (hold && cpuHold !== 1'b0)) && k < 80)
    begin
      cyc(1);
      k++;
    end
    chk(16'(expQ.size()), 16'h0000);
  endtask

  // Mode, enable, request from one source, then an instruction boundary
  task automatic take(input int m, input int src, input logic [7:0] b,
                      input logic blk, input logic [1:0] fl);
    ackByte = b;
    modeSel = 2'(m);
    pulse(modeI);
    pulse(enI);
    srcN[src] = 1'b0;
    cyc(3);
    boundary(blk);
    srcN = 4'hF;
    chk(16'({gFlag, sFlag}), 16'(fl));
  endtask

  initial
  begin : main
    int p;
    int v;
    cyc(8);
    rst_n = 1'b1;
    cyc(4);
    rd(LZV_VECTOR_LOW_ADDR, 8'h00);
    rd(LZV_TRAP_CTRL_ADDR, 8'h01);
    rd(8'h40, 8'h00);
    v = $random(seed);
    wr(LZV_VECTOR_LOW_ADDR, v[7:0]);
    rd(LZV_VECTOR_LOW_ADDR, {v[7:5], 5'h00});
    $display("registers done");
    for (int m = 2; m < 4; m++)
    begin
      irq2N = (m == 2);
      wr(LZV_EDGE_CTRL_ADDR, {m[1:0], 6'h08});
      cyc(4);
      chk(16'(irq2ReqN), 16'h0001);
      irq2N = ~irq2N;
      cyc(4);
      chk(16'(irq2ReqN), 16'h0000);
      irq2N = ~irq2N;
      wr(LZV_EDGE_CTRL_ADDR, {m[1:0], 6'h00});
      cyc(3);
      chk(16'(irq2ReqN), 16'h0000);
      rd(LZV_EDGE_CTRL_ADDR, {m[1:0], 2'h0, irq2N, 3'h0});
      wr(LZV_EDGE_CTRL_ADDR, {m[1:0], 6'h08});
      cyc(3);
      chk(16'(irq2ReqN), 16'h0001);
    end
    wr(LZV_EDGE_CTRL_ADDR, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      irq2N = k[0];
      cyc(4);
      chk(16'(irq2ReqN), 16'(k[0]));
    end
    $display("interrupt 2 done");
    for (int n = 0; n < 8; n++)
    begin
      expQ.push_back(16'(n * 8));
      take(0, n % 4, 8'hC7 | 8'(n << 3), 1'b0, 2'h0);
      settle(1'b1);
    end
    expQ.push_back(LZV_MODE1_TARGET);
    take(1, 2, 8'h00, 1'b0, 2'h0);
    settle(1'b1);
    for (int n = 0; n < 4; n++)
    begin
      p = $random(seed);
      v = $random(seed) & 8'hFE;
      slow = n[0];
      acc = p[7:0];
      pulse(ldPage);
      chk(16'(pageReg), 16'(p[7:0]));
      lo = 8'(p ^ v) ^ 8'hA5;
      expQ.push_back({lo ^ 8'h01, lo});
      take(2, n, v[7:0], 1'b0, 2'h0);
      settle(1'b1);
    end
    $display("takes done");
    expQ.push_back(16'h00ED);
    p = nPush;
    take(0, 1, 8'hED, 1'b0, 2'h0);
    settle(1'b0);
    opBad = 1'b1;
    pulse(opDone);
    opBad = 1'b0;
    settle(1'b1);
    cyc(2);
    chk(16'(nTrap), 16'h0001);
    chk(16'(nPush - p), 16'h0000);
    srcN = 4'h0;
    boundary(1'b0);
    srcN = 4'hF;
    chk(16'({cpuHold, ackPins}), 16'h0003);
    wr(LZV_TRAP_CTRL_ADDR, 8'h00);
    take(2, 0, 8'h10, 1'b0, 2'h3);
    chk(16'({cpuHold, ackPins}), 16'h0003);
    wr(LZV_TRAP_CTRL_ADDR, 8'h01);
    take(2, 1, 8'h10, 1'b1, 2'h3);
    chk(16'({cpuHold, ackPins}), 16'h0003);
    boundary(1'b0);
    $display("refusals done");
    close_out();
  end

  // Whole run is near 2000 ns; this allows a hundred times that
  initial
  begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule // tb_level0_interrupt_vectoring

`default_nettype wire
